// File: rtl/trig_exp_pkg.sv
// Constants, register map and state types of the trigger/exposure sequencer
package trig_exp_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ           = 50;
  localparam int unsigned LEVEL_EXTRA_US    = 682;
  localparam int unsigned LEVEL_EXTRA_CYC   = LEVEL_EXTRA_US * CLK_MHZ;
  localparam int unsigned TRIG_LATENCY_CYC  = 4;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] EXPOSURE_OFS    = 8'h04;
  localparam logic [7:0] DELAY_OFS       = 8'h08;
  localparam logic [7:0] SPIKE_OFS       = 8'h0c;
  localparam logic [7:0] DEBOUNCE_OFS    = 8'h10;
  localparam logic [7:0] STRB_DELAY_OFS  = 8'h14;
  localparam logic [7:0] STRB_WIDTH_OFS  = 8'h18;
  localparam logic [7:0] PIN_SEL_OFS     = 8'h1c;
  localparam logic [7:0] READOUT_OFS     = 8'h20;
  localparam logic [7:0] SEND_LEN_OFS    = 8'h24;
  localparam logic [7:0] STATUS_OFS      = 8'h28;
  localparam logic [7:0] EVENTS_OFS      = 8'h2c;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int unsigned CTRL_RAND_BIT  = 0;
  localparam int unsigned CTRL_POL_BIT   = 1;
  localparam int unsigned CTRL_LEVEL_BIT = 2;
  localparam int unsigned CTRL_USER_BIT  = 3;
  localparam int unsigned CTRL_SWTRG_BIT = 4;
  localparam int unsigned PIN_SEL_W      = 3;
  localparam int unsigned NUM_PINS       = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [4:0]  CTRL_RST       = 5'h00;
  localparam logic [31:0] EXPOSURE_RST   = 32'h0000_8000;
  localparam logic [31:0] SPIKE_RST      = 32'h0000_0005;
  localparam logic [31:0] DEBOUNCE_RST   = 32'h0000_0064;
  localparam logic [31:0] READOUT_RST    = 32'h0000_1000;
  localparam logic [31:0] SEND_LEN_RST   = 32'h0000_1000;

  // ****************************************
  // Event bits
  // ****************************************
  localparam int unsigned EV_ACCEPT   = 0;
  localparam int unsigned EV_REJECT   = 1;
  localparam int unsigned EV_WAIT     = 2;
  localparam int unsigned EV_SEND_B   = 3;
  localparam int unsigned EV_SEND_E   = 4;
  localparam int unsigned EV_INTEG_B  = 5;
  localparam int unsigned EV_INTEG_E  = 6;
  localparam int unsigned EV_STRB_B   = 7;
  localparam int unsigned EV_STRB_E   = 8;
  localparam int unsigned NUM_EV      = 9;

  // ****************************************
  // Pin sources and states
  // ****************************************
  typedef enum logic [2:0] {
    SRC_OFF, SRC_STROBE, SRC_USER, SRC_INTEG, SRC_CAPTURE, SRC_SEND,
    SRC_WAIT
  } pin_src_t;

  typedef enum {
    ST_FREE, ST_WAIT, ST_DELAY, ST_EXPOSE, ST_EXTRA, ST_READOUT, ST_SEND
  } seq_state_t;

  typedef enum {STB_IDLE, STB_DELAY, STB_ON} strobe_state_t;

endpackage

// File: rtl/trigger_exposure_io_control.sv
// Trigger conditioning, exposure sequencer, strobe timer and pin routing
// ****************************************
// How it works
// - Capture from pin or software; software edge-only
// - Trigger polarity high or low selectable
// - Random trigger mode uses global reset
// - Global reset starts all lines together
// - Edge mode: exposure from exposure setting
// - Level mode: exposure follows trigger width
// - Level mode adds fixed 682 us
// - Fixed latency from trigger to exposure
// - Programmable extra trigger delay
// - Trigger passes spike and debounce filters
// - Accept, reject, wait-begin events to host
// - Send, integration, strobe begin/end events
// - Each pin has selectable source
// - Strobe with programmable delay and width
// - User source drives software level
// - Integration window spans exposure
// - Capture window until readout done
// - Send window while image is sent
// - Wait output; trigger then starts at once
// - Free-run exposure timed by internal sync
// ****************************************
//
// Chosen here: the register addresses and register access over AHB-Lite.
module trigger_exposure_io_control #(
  parameter int unsigned LEVEL_EXTRA_CYCLES =
    trig_exp_pkg::LEVEL_EXTRA_CYC
) (
  input  wire logic                                  hclk,
  input  wire logic                                  hresetn,
  input  wire logic                                  hsel,
  input  wire logic [31:0]                           haddr,
  input  wire logic [1:0]                            htrans,
  input  wire logic                                  hwrite,
  input  wire logic [2:0]                            hsize,
  input  wire logic [31:0]                           hwdata,
  input  wire logic                                  hready,
  output logic [31:0]                                hrdata,
  output logic                                       hreadyout,
  output logic                                       hresp,
  input  wire logic                                  trigger_in,
  output logic                                       global_reset_out,
  output logic                                       rolling_reset_out,
  output logic                                       integration_window_out,
  output logic                                       capture_window_out,
  output logic                                       image_send_window_out,
  output logic                                       capture_wait_begin,
  output logic                                       strobe_pulse_out,
  output logic                                       software_level_out,
  output logic [trig_exp_pkg::NUM_PINS-1:0]          line_out,
  output logic [trig_exp_pkg::NUM_EV-1:0]            event_pulse_out
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam logic [31:0] EXTRA_CNT = LEVEL_EXTRA_CYCLES[31:0];
  localparam logic [31:0] LAT_CNT   = trig_exp_pkg::TRIG_LATENCY_CYC;

  logic [4:0]  ctrl_reg;
  logic [31:0] exposure_reg;
  logic [31:0] delay_reg;
  logic [31:0] spike_reg;
  logic [31:0] debounce_reg;
  logic [31:0] strb_delay_reg;
  logic [31:0] strb_width_reg;
  logic [5:0]  pin_sel_reg;
  logic [31:0] readout_reg;
  logic [31:0] send_len_reg;
  logic [trig_exp_pkg::NUM_EV-1:0] events_reg;
  logic        sw_trig_reg;

  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        addr_ok;
  logic        wr_ctrl;

  logic        sync1_reg, sync2_reg, sync3_reg;
  logic        in_lvl_reg;
  logic        spk_reg;
  logic [31:0] spk_cnt_reg;
  logic        deb_reg;
  logic        deb_d_reg;
  logic [31:0] hold_cnt_reg;
  logic        act_lvl;
  logic        trig_rise;

  trig_exp_pkg::seq_state_t    state_reg, state_next;
  trig_exp_pkg::strobe_state_t stb_reg;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] stb_cnt_reg;
  logic        lvl_frame_reg, lvl_frame_next;
  logic [trig_exp_pkg::NUM_EV-1:0] ev_next;
  logic        glob_next, roll_next;
  logic        stb_begin, stb_end;

  // Picks the level a pin shows for a given source code
  function automatic logic pin_pick(input logic [2:0] sel,
                                    input logic [6:0] srcs);
    case (sel)
      trig_exp_pkg::SRC_STROBE:  pin_pick = srcs[1];
      trig_exp_pkg::SRC_USER:    pin_pick = srcs[2];
      trig_exp_pkg::SRC_INTEG:   pin_pick = srcs[3];
      trig_exp_pkg::SRC_CAPTURE: pin_pick = srcs[4];
      trig_exp_pkg::SRC_SEND:    pin_pick = srcs[5];
      trig_exp_pkg::SRC_WAIT:    pin_pick = srcs[6];
      default:                   pin_pick = 1'b0;
    endcase
  endfunction

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign addr_ok = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00) &&
                   (haddr[7:0] <= trig_exp_pkg::EVENTS_OFS);
  assign wr_ctrl = wr_pend_reg && (wr_addr_reg == trig_exp_pkg::CTRL_OFS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= hsel && htrans[1] && hready && hwrite && addr_ok;
      wr_addr_reg <= haddr[7:0];
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  // Read data is fetched in the address phase, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && htrans[1] && hready && !hwrite) begin
      case (addr_ok ? haddr[7:0] : 8'hff)
        trig_exp_pkg::CTRL_OFS:       hrdata <= {27'h0, ctrl_reg};
        trig_exp_pkg::EXPOSURE_OFS:   hrdata <= exposure_reg;
        trig_exp_pkg::DELAY_OFS:      hrdata <= delay_reg;
        trig_exp_pkg::SPIKE_OFS:      hrdata <= spike_reg;
        trig_exp_pkg::DEBOUNCE_OFS:   hrdata <= debounce_reg;
        trig_exp_pkg::STRB_DELAY_OFS: hrdata <= strb_delay_reg;
        trig_exp_pkg::STRB_WIDTH_OFS: hrdata <= strb_width_reg;
        trig_exp_pkg::PIN_SEL_OFS:    hrdata <= {26'h0, pin_sel_reg};
        trig_exp_pkg::READOUT_OFS:    hrdata <= readout_reg;
        trig_exp_pkg::SEND_LEN_OFS:   hrdata <= send_len_reg;
        trig_exp_pkg::STATUS_OFS:     hrdata <= {24'h0, deb_reg,
                                        capture_wait_begin,
                                        image_send_window_out,
                                        capture_window_out,
                                        integration_window_out,
                                        strobe_pulse_out,
                                        line_out};
        trig_exp_pkg::EVENTS_OFS:     hrdata <= {23'h0, events_reg};
        default:                      hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg       <= trig_exp_pkg::CTRL_RST;
      exposure_reg   <= trig_exp_pkg::EXPOSURE_RST;
      delay_reg      <= 32'h0000_0000;
      spike_reg      <= trig_exp_pkg::SPIKE_RST;
      debounce_reg   <= trig_exp_pkg::DEBOUNCE_RST;
      strb_delay_reg <= 32'h0000_0000;
      strb_width_reg <= 32'h0000_0000;
      pin_sel_reg    <= 6'h00;
      readout_reg    <= trig_exp_pkg::READOUT_RST;
      send_len_reg   <= trig_exp_pkg::SEND_LEN_RST;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        trig_exp_pkg::CTRL_OFS:       ctrl_reg       <= {1'b0, hwdata[3:0]};
        trig_exp_pkg::EXPOSURE_OFS:   exposure_reg   <= hwdata;
        trig_exp_pkg::DELAY_OFS:      delay_reg      <= hwdata;
        trig_exp_pkg::SPIKE_OFS:      spike_reg      <= hwdata;
        trig_exp_pkg::DEBOUNCE_OFS:   debounce_reg   <= hwdata;
        trig_exp_pkg::STRB_DELAY_OFS: strb_delay_reg <= hwdata;
        trig_exp_pkg::STRB_WIDTH_OFS: strb_width_reg <= hwdata;
        trig_exp_pkg::PIN_SEL_OFS:    pin_sel_reg    <= hwdata[5:0];
        trig_exp_pkg::READOUT_OFS:    readout_reg    <= hwdata;
        trig_exp_pkg::SEND_LEN_OFS:   send_len_reg   <= hwdata;
        default:                      ctrl_reg       <= ctrl_reg;
      endcase
    end
  end

  // Software capture command, one-cycle pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_trig_reg <= 1'b0;
    end else begin
      sw_trig_reg <= wr_ctrl && hwdata[trig_exp_pkg::CTRL_SWTRG_BIT];
    end
  end

  // Sticky event record; new events win over write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      events_reg <= '0;
    end else if (wr_pend_reg && wr_addr_reg == trig_exp_pkg::EVENTS_OFS) begin
      events_reg <= (events_reg & ~hwdata[trig_exp_pkg::NUM_EV-1:0]) |
                    ev_next;
    end else begin
      events_reg <= events_reg | ev_next;
    end
  end

  // ****************************************
  // Trigger input conditioning
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Idle level of the default low-active pin, no edge after reset
      sync1_reg  <= 1'b1;
      sync2_reg  <= 1'b1;
      sync3_reg  <= 1'b1;
      in_lvl_reg <= 1'b1;
    end else begin
      sync1_reg <= trigger_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        in_lvl_reg <= sync3_reg;
      end
    end
  end

  assign act_lvl = ctrl_reg[trig_exp_pkg::CTRL_POL_BIT] ? in_lvl_reg :
                   !in_lvl_reg;

  // Spike rejection: a new level must persist for the set count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spk_reg     <= 1'b0;
      spk_cnt_reg <= 32'h0000_0000;
    end else if (act_lvl == spk_reg) begin
      spk_cnt_reg <= 32'h0000_0000;
    end else if (spk_cnt_reg >= spike_reg) begin
      spk_reg     <= act_lvl;
      spk_cnt_reg <= 32'h0000_0000;
    end else begin
      spk_cnt_reg <= spk_cnt_reg + 32'h0000_0001;
    end
  end

  // Debounce: after a change, further changes are held off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deb_reg      <= 1'b0;
      deb_d_reg    <= 1'b0;
      hold_cnt_reg <= 32'h0000_0000;
    end else begin
      deb_d_reg <= deb_reg;
      if (hold_cnt_reg != 32'h0000_0000) begin
        hold_cnt_reg <= hold_cnt_reg - 32'h0000_0001;
      end else if (spk_reg != deb_reg) begin
        deb_reg      <= spk_reg;
        hold_cnt_reg <= debounce_reg;
      end
    end
  end

  assign trig_rise = deb_reg && !deb_d_reg;

  // ****************************************
  // Exposure sequencer
  // ****************************************
  always_comb begin
    state_next     = state_reg;
    cnt_next       = (cnt_reg != 32'h0) ? cnt_reg - 32'h1 : cnt_reg;
    lvl_frame_next = lvl_frame_reg;
    ev_next        = '0;
    glob_next      = 1'b0;
    roll_next      = 1'b0;
    ev_next[trig_exp_pkg::EV_STRB_B] = stb_begin;
    ev_next[trig_exp_pkg::EV_STRB_E] = stb_end;
    // In random mode, any trigger outside the wait state is refused
    if (ctrl_reg[trig_exp_pkg::CTRL_RAND_BIT] &&
        state_reg != trig_exp_pkg::ST_WAIT && trig_rise) begin
      ev_next[trig_exp_pkg::EV_REJECT] = 1'b1;
    end
    if (sw_trig_reg && (state_reg != trig_exp_pkg::ST_WAIT ||
        ctrl_reg[trig_exp_pkg::CTRL_LEVEL_BIT])) begin
      ev_next[trig_exp_pkg::EV_REJECT] = 1'b1;
    end
    case (state_reg)
      trig_exp_pkg::ST_FREE: begin
        if (ctrl_reg[trig_exp_pkg::CTRL_RAND_BIT]) begin
          state_next = trig_exp_pkg::ST_WAIT;
          ev_next[trig_exp_pkg::EV_WAIT] = 1'b1;
        end else begin
          state_next     = trig_exp_pkg::ST_EXPOSE;
          cnt_next       = exposure_reg;
          lvl_frame_next = 1'b0;
          roll_next      = 1'b1;
          ev_next[trig_exp_pkg::EV_INTEG_B] = 1'b1;
        end
      end
      trig_exp_pkg::ST_WAIT: begin
        if (!ctrl_reg[trig_exp_pkg::CTRL_RAND_BIT]) begin
          state_next = trig_exp_pkg::ST_FREE;
        end else if (trig_rise || (sw_trig_reg &&
                     !ctrl_reg[trig_exp_pkg::CTRL_LEVEL_BIT])) begin
          state_next     = trig_exp_pkg::ST_DELAY;
          cnt_next       = LAT_CNT + delay_reg;
          lvl_frame_next = ctrl_reg[trig_exp_pkg::CTRL_LEVEL_BIT] &&
                           !sw_trig_reg;
          ev_next[trig_exp_pkg::EV_ACCEPT] = 1'b1;
        end
      end
      trig_exp_pkg::ST_DELAY: begin
        if (cnt_reg == 32'h0) begin
          state_next = trig_exp_pkg::ST_EXPOSE;
          cnt_next   = exposure_reg;
          glob_next  = 1'b1;
          ev_next[trig_exp_pkg::EV_INTEG_B] = 1'b1;
        end
      end
      trig_exp_pkg::ST_EXPOSE: begin
        if (lvl_frame_reg) begin
          if (!deb_reg) begin
            state_next = trig_exp_pkg::ST_EXTRA;
            // Latency and delay given back: exposure spans the whole pulse
            cnt_next   = EXTRA_CNT + LAT_CNT + delay_reg + 32'h1;
          end
        end else if (cnt_reg == 32'h0) begin
          state_next = trig_exp_pkg::ST_READOUT;
          cnt_next   = readout_reg;
          ev_next[trig_exp_pkg::EV_INTEG_E] = 1'b1;
        end
      end
      trig_exp_pkg::ST_EXTRA: begin
        if (cnt_reg == 32'h0) begin
          state_next = trig_exp_pkg::ST_READOUT;
          cnt_next   = readout_reg;
          ev_next[trig_exp_pkg::EV_INTEG_E] = 1'b1;
        end
      end
      trig_exp_pkg::ST_READOUT: begin
        if (cnt_reg == 32'h0) begin
          state_next = trig_exp_pkg::ST_SEND;
          cnt_next   = send_len_reg;
          ev_next[trig_exp_pkg::EV_SEND_B] = 1'b1;
        end
      end
      trig_exp_pkg::ST_SEND: begin
        if (cnt_reg == 32'h0) begin
          ev_next[trig_exp_pkg::EV_SEND_E] = 1'b1;
          if (ctrl_reg[trig_exp_pkg::CTRL_RAND_BIT]) begin
            state_next = trig_exp_pkg::ST_WAIT;
            ev_next[trig_exp_pkg::EV_WAIT] = 1'b1;
          end else begin
            state_next = trig_exp_pkg::ST_FREE;
          end
        end
      end
      default: begin
        state_next = trig_exp_pkg::ST_FREE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg     <= trig_exp_pkg::ST_FREE;
      cnt_reg       <= 32'h0000_0000;
      lvl_frame_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      lvl_frame_reg <= lvl_frame_next;
    end
  end

  // ****************************************
  // Strobe timer, started at integration begin
  // ****************************************
  assign stb_begin = (stb_reg == trig_exp_pkg::STB_DELAY) &&
                     (stb_cnt_reg == 32'h0);
  assign stb_end   = (stb_begin && strb_width_reg == 32'h0) ||
                     ((stb_reg == trig_exp_pkg::STB_ON) &&
                      (stb_cnt_reg == 32'h0));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stb_reg     <= trig_exp_pkg::STB_IDLE;
      stb_cnt_reg <= 32'h0000_0000;
    end else begin
      case (stb_reg)
        trig_exp_pkg::STB_IDLE: begin
          if (ev_next[trig_exp_pkg::EV_INTEG_B]) begin
            stb_reg     <= trig_exp_pkg::STB_DELAY;
            stb_cnt_reg <= strb_delay_reg;
          end
        end
        trig_exp_pkg::STB_DELAY: begin
          if (stb_cnt_reg != 32'h0) begin
            stb_cnt_reg <= stb_cnt_reg - 32'h1;
          end else if (strb_width_reg == 32'h0) begin
            stb_reg <= trig_exp_pkg::STB_IDLE;
          end else begin
            stb_reg     <= trig_exp_pkg::STB_ON;
            stb_cnt_reg <= strb_width_reg - 32'h1;
          end
        end
        trig_exp_pkg::STB_ON: begin
          if (stb_cnt_reg != 32'h0) begin
            stb_cnt_reg <= stb_cnt_reg - 32'h1;
          end else begin
            stb_reg <= trig_exp_pkg::STB_IDLE;
          end
        end
        default: begin
          stb_reg <= trig_exp_pkg::STB_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Registered status outputs and pin routing
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_reset_out       <= 1'b0;
      rolling_reset_out      <= 1'b0;
      integration_window_out <= 1'b0;
      capture_window_out     <= 1'b0;
      image_send_window_out  <= 1'b0;
      capture_wait_begin     <= 1'b0;
      strobe_pulse_out       <= 1'b0;
      software_level_out     <= 1'b0;
      event_pulse_out        <= '0;
    end else begin
      global_reset_out       <= glob_next;
      rolling_reset_out      <= roll_next;
      integration_window_out <= state_next == trig_exp_pkg::ST_EXPOSE ||
                                state_next == trig_exp_pkg::ST_EXTRA;
      capture_window_out     <= state_next == trig_exp_pkg::ST_EXPOSE ||
                                state_next == trig_exp_pkg::ST_EXTRA ||
                                state_next == trig_exp_pkg::ST_READOUT;
      image_send_window_out  <= state_next == trig_exp_pkg::ST_SEND;
      capture_wait_begin     <= state_next == trig_exp_pkg::ST_WAIT;
      strobe_pulse_out       <= (stb_begin && strb_width_reg != 32'h0) ||
                                (stb_reg == trig_exp_pkg::STB_ON &&
                                 stb_cnt_reg != 32'h0);
      software_level_out     <= ctrl_reg[trig_exp_pkg::CTRL_USER_BIT];
      event_pulse_out        <= ev_next;
    end
  end

  generate
    for (genvar p = 0; p < trig_exp_pkg::NUM_PINS; p++) begin : g_pin
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          line_out[p] <= 1'b0;
        end else begin
          line_out[p] <= pin_pick(
            pin_sel_reg[p*trig_exp_pkg::PIN_SEL_W +: 3],
            {capture_wait_begin, image_send_window_out, capture_window_out,
             integration_window_out, software_level_out, strobe_pulse_out,
             1'b0});
        end
      end
    end
  endgenerate

endmodule

// File: sim/trig_exp_monitor.sv
// Concurrent checks on the sequencer outputs
module trig_exp_monitor (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       global_reset_out,
  input wire logic       rolling_reset_out,
  input wire logic       integration_window_out,
  input wire logic       capture_window_out,
  input wire logic       image_send_window_out,
  input wire logic       capture_wait_begin,
  input wire logic       strobe_pulse_out,
  input wire logic [8:0] event_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_exposing;
    integration_window_out && capture_window_out;
  endsequence
  AST_GRST_OPENS: assert property (global_reset_out |-> ##[0:1] s_exposing)
    else $error("global reset without exposure");
  AST_GRST_PULSE: assert property (global_reset_out |=> !global_reset_out)
    else $error("global reset longer than one cycle");
  AST_ONE_RESET: assert property (!(global_reset_out && rolling_reset_out))
    else $error("both reset kinds at once");
  AST_FRAME_SPAN: assert property (integration_window_out |-> capture_window_out)
    else $error("capture window low during exposure");
  AST_ACCEPT_WAIT: assert property (event_pulse_out[0] |-> !capture_wait_begin)
    else $error("still waiting after accept");
  AST_ACC_REJ: assert property (!(event_pulse_out[0] && event_pulse_out[1]))
    else $error("accept and reject together");
  AST_INTEG_EV: assert property (event_pulse_out[5] |-> ##[0:1] s_exposing)
    else $error("integration begin without window");
  AST_SEND_EV: assert property (event_pulse_out[3] |-> ##[0:1] image_send_window_out)
    else $error("send begin without window");
  AST_STRB_ON: assert property (event_pulse_out[7] && !event_pulse_out[8]
    |-> strobe_pulse_out)
    else $error("strobe begin without pulse");
  AST_STRB_OFF: assert property (event_pulse_out[8] |-> !strobe_pulse_out)
    else $error("strobe end with pulse high");
endmodule

// File: sim/trig_source_model.sv
// External trigger source on the pin
module trig_source_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        fire,
  input  wire logic        rude,
  input  wire logic [15:0] len,
  input  wire logic        capture_wait_begin,
  output logic             trigger_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_reg;
  // Fires only while waiting, unless told to misbehave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_reg <= 16'h0;
    else if (fire && (rude || capture_wait_begin)) cnt_reg <= len;
    else if (cnt_reg != 16'h0) cnt_reg <= cnt_reg - 16'h1;
  end
  assign trigger_in = (cnt_reg != 16'h0);
endmodule

// File: sim/trigger_exposure_io_control_bench.sv
// Register-level tests of the trigger and exposure sequencer
module trigger_exposure_io_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LX = 20;
  logic hclk, hresetn, hwrite, hready, trigger_in, fire, rude, cwb, iw;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, line_out;
  logic [15:0] len;
  int error_cnt = 0, checks = 0, n;
  trigger_exposure_io_control #(.LEVEL_EXTRA_CYCLES(LX)) i_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(), .trigger_in(trigger_in),
    .global_reset_out(), .rolling_reset_out(), .integration_window_out(iw),
    .capture_window_out(), .image_send_window_out(), .capture_wait_begin(cwb),
    .strobe_pulse_out(), .software_level_out(), .line_out(line_out),
    .event_pulse_out());
  trig_source_model i_src (.hclk(hclk), .hresetn(hresetn), .fire(fire),
    .rude(rude), .len(len), .capture_wait_begin(cwb), .trigger_in(trigger_in));
  task automatic conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  // Pulse the source, optionally outside the wait window
  task automatic shoot(input logic r, input logic [15:0] l);
    fire <= 1'b1; rude <= r; len <= l;
    @(posedge hclk);
    fire <= 1'b0;
  endtask
  task automatic await_wait;
    int t = 0;
    while (cwb !== 1'b1 && t < 50000) begin @(posedge hclk); t++; end
  endtask
  task automatic expo(output int c);
    int t = 0;
    c = 0;
    while (iw !== 1'b1 && t < 5000) begin @(posedge hclk); t++; end
    while (iw === 1'b1) begin @(posedge hclk); c++; end
  endtask
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hwdata = 32'h0; fire = 1'b0; rude = 1'b0; len = 16'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rc("ctrl", 8'h00, 32'h0);
    rc("exposure", 8'h04, 32'h8000);
    rc("debounce", 8'h10, 32'h64);
    rc("unmapped", 8'h30, 32'h0);
    wr(8'h04, 32'd20); wr(8'h08, 32'd3); wr(8'h0c, 32'd1); wr(8'h10, 32'd2);
    wr(8'h14, 32'd2); wr(8'h18, 32'd3); wr(8'h20, 32'd10); wr(8'h24, 32'd10);
    rc("exposure", 8'h04, 32'd20);
    wr(8'h1c, 32'h16); wr(8'h00, 32'h0b);
    await_wait;
    @(posedge hclk);
    chk("pins", 32'h3, {30'h0, line_out});
    shoot(1'b0, 16'd5); expo(n);
    chk("edge exposure", 32'd21, n);
    shoot(1'b1, 16'd5); await_wait;
    rc("events", 8'h2c, 32'h1ff);
    wr(8'h00, 32'h0f); shoot(1'b0, 16'd30); expo(n);
    chk("level exposure", 32'd30 + LX + 1, n);
    await_wait; wr(8'h2c, 32'h1ff); wr(8'h00, 32'h1f);
    repeat (8) @(posedge hclk);
    rc("sw in level", 8'h2c, 32'h2);
    wr(8'h00, 32'h1b); expo(n);
    chk("sw exposure", 32'd21, n);
    conclude;
  end
  initial begin
    #1ms;
    error_cnt++;
    conclude;
  end
endmodule
bind trigger_exposure_io_control trig_exp_monitor i_mon (.hclk(hclk),
  .hresetn(hresetn), .global_reset_out(global_reset_out),
  .rolling_reset_out(rolling_reset_out),
  .integration_window_out(integration_window_out),
  .capture_window_out(capture_window_out),
  .image_send_window_out(image_send_window_out),
  .capture_wait_begin(capture_wait_begin),
  .strobe_pulse_out(strobe_pulse_out), .event_pulse_out(event_pulse_out));
